// ===== pkg/bsm_pkg.sv
// shared constants and types for the cell measurement controller and its host
`default_nettype none
package bsm_pkg;
	// ==========================================================
	// sizes
	localparam int CELLS  = 12;
	localparam int TEN    = 10;
	localparam int TEMPS  = 3;
	localparam int CODE_W = 12;
	localparam int DATA_W = 16;

	// ==========================================================
	// commands on the link
	typedef enum logic [3:0] {
		CMD_CFG      = 4'h0, // write configuration word
		CMD_CELL     = 4'h1, // cell_convert_cmd
		CMD_OW       = 4'h2, // open_wire_convert_cmd
		CMD_CELL_DC  = 4'h3, // cell_convert_keep_discharge_cmd
		CMD_OW_DC    = 4'h4, // open_wire_convert_keep_discharge_cmd
		CMD_ONE_CELL = 4'h5, // convert the single cell in data[3:0]
		CMD_TEMP     = 4'h6, // convert temperature inputs
		CMD_ST1_CELL = 4'h7,
		CMD_ST2_CELL = 4'h8,
		CMD_ST1_TEMP = 4'h9,
		CMD_ST2_TEMP = 4'hA,
		CMD_RD_CELL  = 4'hB, // read_cell_results_cmd
		CMD_RD_TEMP  = 4'hC, // read_temperature_group_cmd
		CMD_OW_CHECK = 4'hD  // host-side open-wire sequence, never sent
	} cmd_e;

	// ==========================================================
	// configuration word layout and reset values
	localparam int          CFG_DIS_LSB  = 0;
	localparam int          CFG_TEN_BIT  = 12;
	localparam int          CFG_CDC_LSB  = 13;
	localparam logic [11:0] DIS_RST      = 12'h000;
	localparam logic        TEN_RST      = 1'b0;
	localparam logic [2:0]  CDC_RST      = 3'h0;
	localparam logic [2:0]  CDC_STANDBY  = 3'h0;
	localparam logic [2:0]  CDC_SELFTEST = 3'h1;

	// ==========================================================
	// self-test codes and temperature group layout
	localparam logic [11:0] ST1_CODE  = 12'h555;
	localparam logic [11:0] ST2_CODE  = 12'hAAA;
	localparam logic [3:0]  FLAG_WORD = 4'h3; // word after the temperatures
	localparam int          THERMAL_SHUTDOWN_FLAG_BIT  = 0;

	// ==========================================================
	// timing
	localparam int CLK_HZ          = 10_000_000;
	localparam int CONV_TIME_US    = 100;
	localparam int CONV_CYCLES     = CONV_TIME_US * (CLK_HZ / 1_000_000);
	localparam int CMP_TIME_US     = 20;
	localparam int CMP_CYCLES      = CMP_TIME_US * (CLK_HZ / 1_000_000);
	localparam int CMP_PERIOD_US   = 400;
	localparam int CMP_PERIOD_CYC  = CMP_PERIOD_US * (CLK_HZ / 1_000_000);

	// ==========================================================
	// open-wire detection
	localparam int OW_REPEAT     = 3;
	localparam int OW_THRESH_MV  = 200;
	localparam int CODE_LSB_UV   = 1000;
	localparam int OW_THRESH_CODE = OW_THRESH_MV * 1000 / CODE_LSB_UV;
endpackage
`default_nettype wire

// ===== pkg/bsm_link.sv
// command and response link between host and measurement controller
`default_nettype none
interface bsm_link;
	logic                       cmd_valid;
	logic                       cmd_ready;
	bsm_pkg::cmd_e              cmd_code;
	logic [bsm_pkg::DATA_W-1:0] cmd_data;
	logic                       rsp_valid;
	logic [3:0]                 rsp_index;
	logic [bsm_pkg::CODE_W-1:0] rsp_data;
	logic                       rsp_last;

	modport dev (input cmd_valid, cmd_code, cmd_data, output cmd_ready, rsp_valid, rsp_index, rsp_data, rsp_last);
	modport host (output cmd_valid, cmd_code, cmd_data, input cmd_ready, rsp_valid, rsp_index, rsp_data, rsp_last);
endinterface
`default_nettype wire

// ===== core/cell_measure_discharge_ctrl.sv
// device end: conversion sequencer, discharge gating, self test and thermal shutdown
// How it works
// - open-wire runs keep test currents on throughout
// - primary converts gate own and neighbour switches
// - keep-discharge converts leave enabled switches on
// - comparisons running force all switches off
// - self test one writes 0x555 everywhere
// - self test two writes 0xAAA everywhere
// - self test takes full conversion time
// - host sets duty field one before self test
// - overheating resets configuration, stops conversions
// - thermal flag set and held after shutdown
// - reading temperature group clears thermal flag
// - ten-cell select picks 10 or 12 cells
// - host reads all 10 or 12 results
// - single cell conversion command accepted
// - host compares normal and open-wire readings
// - host repeats open-wire run for large caps
// - ten-cell select resets low
// - duty field zero means standby
// - switch settings follow host configuration and overheating reset only
`default_nettype none
module cell_measure_discharge_ctrl #(
	parameter int CONV_CYC  = bsm_pkg::CONV_CYCLES,
	parameter int CMP_CYC   = bsm_pkg::CMP_CYCLES,
	parameter int CMP_PER   = bsm_pkg::CMP_PERIOD_CYC
) (
	input  wire logic                       clk,              // 10 MHz clock
	input  wire logic                       rst_n,            // synchronous reset
	bsm_link.dev                            link,             // host command link
	input  wire logic [bsm_pkg::CODE_W-1:0] adc_code,         // converter result, same clock
	input  wire logic                       die_hot,          // over-temperature comparator, async
	output logic [bsm_pkg::CELLS-1:0]       discharge_switch_output, // discharge switch drives
	output logic [3:0]                      mux_chan,         // channel being converted
	output logic                            meas_temp,        // channel is a temperature input
	output logic                            test_current_on,  // open-wire current sources
	output logic                            test_signal_on,   // self-test signal applied
	output logic                            compare_active,   // uv/ov comparison running
	output logic                            standby           // measurement circuits off
);
	// ==========================================================
	// state
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_CONV = 3'b010,
		S_READ = 3'b100
	} state_e;

	typedef struct packed {
		state_e                                          st;
		bsm_pkg::cmd_e                                   kind;
		logic [3:0]                                      chan;
		logic [3:0]                                      last;
		logic [15:0]                                     timer;
		logic [15:0]                                     cmp_timer;
		logic [bsm_pkg::CELLS-1:0]                       dis;
		logic                                            ten;
		logic [2:0]                                      cdc;
		logic                                            thermal_shutdown_flag;
		logic                                            hot_s1;
		logic                                            hot_s2;
		logic                                            hot_prev;
		logic [bsm_pkg::CELLS-1:0][bsm_pkg::CODE_W-1:0]  cells;
		logic [bsm_pkg::TEMPS-1:0][bsm_pkg::CODE_W-1:0]  temps;
		logic                                            rsp_valid;
		logic [3:0]                                      rsp_index;
		logic [bsm_pkg::CODE_W-1:0]                      rsp_data;
		logic                                            rsp_last;
		logic [bsm_pkg::CELLS-1:0]                       dis_out;
	} state_s;

	state_s s;
	state_s next_s;

	// ==========================================================
	// decoders
	// switches of the measured cell and the ones just above and below
	function automatic logic [bsm_pkg::CELLS-1:0] neighbour_mask(input logic [3:0] ch);
		logic [bsm_pkg::CELLS+1:0] m;
		m = 14'h0007 << ch;
		return m[bsm_pkg::CELLS:1];
	endfunction

	function automatic logic is_ow(input bsm_pkg::cmd_e c);
		return c == bsm_pkg::CMD_OW || c == bsm_pkg::CMD_OW_DC;
	endfunction

	function automatic logic is_selftest(input bsm_pkg::cmd_e c);
		return c == bsm_pkg::CMD_ST1_CELL || c == bsm_pkg::CMD_ST2_CELL ||
			c == bsm_pkg::CMD_ST1_TEMP || c == bsm_pkg::CMD_ST2_TEMP;
	endfunction

	function automatic logic is_temp(input bsm_pkg::cmd_e c);
		return c == bsm_pkg::CMD_TEMP || c == bsm_pkg::CMD_ST1_TEMP ||
			c == bsm_pkg::CMD_ST2_TEMP || c == bsm_pkg::CMD_RD_TEMP;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic                       hot_rise;
		logic [bsm_pkg::CODE_W-1:0] result;
		logic [3:0]                 cell_last;
		hot_rise  = 1'b0;
		result    = '0;
		cell_last = '0;
		next_s    = s;
		next_s.rsp_valid = 1'b0;
		next_s.rsp_last  = 1'b0;
		// over-temperature comparator is asynchronous: two flops before use
		next_s.hot_s1   = die_hot;
		next_s.hot_s2   = s.hot_s1;
		next_s.hot_prev = s.hot_s2;
		hot_rise  = s.hot_s2 & ~s.hot_prev;
		cell_last = s.ten ? 4'(bsm_pkg::TEN - 1) : 4'(bsm_pkg::CELLS - 1);

		unique case (s.st)
			S_IDLE: begin
				if (link.cmd_valid) begin
					next_s.kind  = link.cmd_code;
					next_s.chan  = '0;
					next_s.timer = '0;
					unique case (link.cmd_code)
						bsm_pkg::CMD_CFG: begin
							// switches change only through this write or an overheating reset
							next_s.dis = link.cmd_data[bsm_pkg::CFG_DIS_LSB +: bsm_pkg::CELLS];
							next_s.ten = link.cmd_data[bsm_pkg::CFG_TEN_BIT];
							next_s.cdc = link.cmd_data[bsm_pkg::CFG_CDC_LSB +: 3];
						end
						bsm_pkg::CMD_RD_CELL: begin
							next_s.st   = S_READ;
							next_s.last = cell_last;
						end
						bsm_pkg::CMD_RD_TEMP: begin
							next_s.st   = S_READ;
							next_s.last = bsm_pkg::FLAG_WORD;
						end
						bsm_pkg::CMD_ONE_CELL: begin
							// out-of-range cell numbers are refused
							if (s.cdc != bsm_pkg::CDC_STANDBY &&
								link.cmd_data[3:0] < 4'(bsm_pkg::CELLS)) begin
								next_s.st   = S_CONV;
								next_s.chan = link.cmd_data[3:0];
								next_s.last = link.cmd_data[3:0];
							end
						end
						default: begin
							// conversions are refused in standby
							if (s.cdc != bsm_pkg::CDC_STANDBY) begin
								next_s.st   = S_CONV;
								next_s.last = is_temp(link.cmd_code) ? 4'(bsm_pkg::TEMPS - 1) : cell_last;
							end
						end
					endcase
				end
			end
			S_CONV: begin
				if (s.timer == 16'(CONV_CYC - 1)) begin
					// self tests store fixed codes but walk the same channels
					if (s.kind == bsm_pkg::CMD_ST1_CELL || s.kind == bsm_pkg::CMD_ST1_TEMP)
						result = bsm_pkg::ST1_CODE;
					else if (s.kind == bsm_pkg::CMD_ST2_CELL || s.kind == bsm_pkg::CMD_ST2_TEMP)
						result = bsm_pkg::ST2_CODE;
					else
						result = adc_code;
					if (is_temp(s.kind))
						next_s.temps[s.chan[1:0]] = result;
					else
						next_s.cells[s.chan] = result;
					next_s.timer = '0;
					if (s.chan == s.last)
						next_s.st = S_IDLE;
					else
						next_s.chan = s.chan + 4'h1;
				end else begin
					next_s.timer = s.timer + 16'h0001;
				end
				// standby interrupts a run; results are then undefined
				if (s.cdc == bsm_pkg::CDC_STANDBY)
					next_s.st = S_IDLE;
			end
			S_READ: begin
				next_s.rsp_valid = 1'b1;
				next_s.rsp_index = s.chan;
				next_s.rsp_last  = (s.chan == s.last);
				if (!is_temp(s.kind))
					next_s.rsp_data = s.cells[s.chan];
				else if (s.chan == bsm_pkg::FLAG_WORD) begin
					next_s.rsp_data = 12'(s.thermal_shutdown_flag) << bsm_pkg::THERMAL_SHUTDOWN_FLAG_BIT;
					next_s.thermal_shutdown_flag     = 1'b0;
				end
				else
					next_s.rsp_data = s.temps[s.chan[1:0]];
				if (s.chan == s.last)
					next_s.st = S_IDLE;
				else
					next_s.chan = s.chan + 4'h1;
			end
			default: next_s.st = S_IDLE; // one-hot code may be corrupted
		endcase

		// comparisons run between commands, once every CMP_PER cycles unless in standby
		if (s.st == S_IDLE && s.cdc != bsm_pkg::CDC_STANDBY)
			next_s.cmp_timer = (s.cmp_timer == 16'(CMP_PER - 1)) ? 16'h0000 : s.cmp_timer + 16'h0001;
		else
			next_s.cmp_timer = '0;

		// overheating: defaults back, runs stop, flag set after any clear
		if (hot_rise) begin
			next_s.dis  = bsm_pkg::DIS_RST;
			next_s.ten  = bsm_pkg::TEN_RST;
			next_s.cdc  = bsm_pkg::CDC_RST;
			next_s.st   = S_IDLE;
			next_s.thermal_shutdown_flag = 1'b1;
		end

		// switch drive follows the next state so gating lines up with the channel
		if (next_s.st == S_IDLE && next_s.cdc != bsm_pkg::CDC_STANDBY &&
			next_s.cmp_timer < 16'(CMP_CYC))
			next_s.dis_out = '0;
		else if (next_s.st == S_CONV && (next_s.kind == bsm_pkg::CMD_CELL ||
			next_s.kind == bsm_pkg::CMD_OW || next_s.kind == bsm_pkg::CMD_ONE_CELL))
			next_s.dis_out = next_s.dis & ~neighbour_mask(next_s.chan);
		else
			next_s.dis_out = next_s.dis;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s       <= '0;
			s.st    <= S_IDLE;
			s.kind  <= bsm_pkg::CMD_CFG;
			s.dis   <= bsm_pkg::DIS_RST;
			s.ten   <= bsm_pkg::TEN_RST;
			s.cdc   <= bsm_pkg::CDC_RST;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign link.cmd_ready          = (s.st == S_IDLE);
	assign link.rsp_valid          = s.rsp_valid;
	assign link.rsp_index          = s.rsp_index;
	assign link.rsp_data           = s.rsp_data;
	assign link.rsp_last           = s.rsp_last;
	assign discharge_switch_output = s.dis_out;
	assign mux_chan                = s.chan;
	assign meas_temp               = (s.st == S_CONV) && is_temp(s.kind);
	assign test_current_on         = (s.st == S_CONV) && is_ow(s.kind);
	assign test_signal_on          = (s.st == S_CONV) && is_selftest(s.kind);
	assign compare_active          = (s.st == S_IDLE) && (s.cdc != bsm_pkg::CDC_STANDBY) &&
		(s.cmp_timer < 16'(CMP_CYC));
	assign standby                 = (s.cdc == bsm_pkg::CDC_STANDBY);
endmodule // cell_measure_discharge_ctrl
`default_nettype wire

// ===== core/bsm_host.sv
// host end: forwards commands, prepares self tests, runs open-wire detection
`default_nettype none
module bsm_host #(
	parameter int OW_REP = bsm_pkg::OW_REPEAT,
	parameter int THRESH = bsm_pkg::OW_THRESH_CODE
) (
	input  wire logic                       clk,            // 10 MHz clock
	input  wire logic                       rst_n,          // synchronous reset
	bsm_link.host                           link,           // device link
	input  wire logic                       user_cmd_valid, // user command request
	input  wire bsm_pkg::cmd_e              user_cmd_code,  // user command code
	input  wire logic [bsm_pkg::DATA_W-1:0] user_cmd_data,  // user command data
	output logic                            user_cmd_ready, // host idle
	output logic                            user_rsp_valid, // copied result word
	output logic [3:0]                      user_rsp_index, // result word index
	output logic [bsm_pkg::CODE_W-1:0]      user_rsp_data,  // result word
	output logic [bsm_pkg::CELLS-2:0]       open_mask,      // open inputs 1..11
	output logic                            ow_done         // open-wire check finished
);
	// ==========================================================
	// state
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_SEND = 4'b0010,
		H_HOLD = 4'b0100,
		H_WAIT = 4'b1000
	} hstate_e;

	typedef struct packed {
		hstate_e                                         st;
		bsm_pkg::cmd_e                                   code;
		logic [bsm_pkg::DATA_W-1:0]                      data;
		bsm_pkg::cmd_e                                   pend_code;
		logic [bsm_pkg::DATA_W-1:0]                      pend_data;
		logic                                            pend;
		logic [2:0]                                      ow_step;
		logic [7:0]                                      ow_rep;
		logic [bsm_pkg::DATA_W-1:0]                      shadow;
		logic [bsm_pkg::CELLS-1:0][bsm_pkg::CODE_W-1:0]  cella;
		logic [bsm_pkg::CELLS-2:0]                       mask;
		logic                                            done;
		logic                                            rsp_valid;
		logic [3:0]                                      rsp_index;
		logic [bsm_pkg::CODE_W-1:0]                      rsp_data;
	} hstate_s;

	hstate_s s;
	hstate_s next_s;

	// ==========================================================
	// next state
	always_comb begin
		next_s           = s;
		next_s.done      = 1'b0;
		next_s.rsp_valid = link.rsp_valid;
		next_s.rsp_index = link.rsp_index;
		next_s.rsp_data  = link.rsp_data;
		// baseline readings first, then the open-wire readings compared
		if (link.rsp_valid && s.ow_step == 3'd2)
			next_s.cella[link.rsp_index] = link.rsp_data;
		if (link.rsp_valid && s.ow_step == 3'd4 && link.rsp_index != 4'h0 &&
			{1'b0, link.rsp_data} >= {1'b0, s.cella[link.rsp_index]} + 13'(THRESH))
			next_s.mask[link.rsp_index - 4'h1] = 1'b1;

		unique case (s.st)
			H_IDLE: begin
				if (user_cmd_valid) begin
					next_s.st   = H_SEND;
					next_s.code = user_cmd_code;
					next_s.data = user_cmd_data;
					if (user_cmd_code == bsm_pkg::CMD_OW_CHECK) begin
						next_s.code    = bsm_pkg::CMD_CELL;
						next_s.ow_step = 3'd1;
						next_s.mask    = '0;
					end else if ((user_cmd_code == bsm_pkg::CMD_ST1_CELL || user_cmd_code == bsm_pkg::CMD_ST2_CELL ||
						user_cmd_code == bsm_pkg::CMD_ST1_TEMP || user_cmd_code == bsm_pkg::CMD_ST2_TEMP) &&
						s.shadow[bsm_pkg::CFG_CDC_LSB +: 3] != bsm_pkg::CDC_SELFTEST) begin
						// duty field must be one before a self test
						next_s.code      = bsm_pkg::CMD_CFG;
						next_s.data      = s.shadow;
						next_s.data[bsm_pkg::CFG_CDC_LSB +: 3] = bsm_pkg::CDC_SELFTEST;
						next_s.shadow[bsm_pkg::CFG_CDC_LSB +: 3] = bsm_pkg::CDC_SELFTEST;
						next_s.pend      = 1'b1;
						next_s.pend_code = user_cmd_code;
						next_s.pend_data = user_cmd_data;
					end else if (user_cmd_code == bsm_pkg::CMD_CFG) begin
						next_s.shadow = user_cmd_data;
					end
				end
			end
			H_SEND: begin
				if (link.cmd_ready)
					next_s.st = H_HOLD;
			end
			H_HOLD: next_s.st = H_WAIT; // device ready falls one cycle after taking
			H_WAIT: begin
				if (link.cmd_ready) begin
					next_s.st = H_SEND;
					if (s.pend) begin
						next_s.pend = 1'b0;
						next_s.code = s.pend_code;
						next_s.data = s.pend_data;
					end else if (s.ow_step == 3'd1 || s.ow_step == 3'd3 && s.ow_rep >= 8'(OW_REP)) begin
						// device streams every 10 or 12 results
						next_s.code    = bsm_pkg::CMD_RD_CELL;
						next_s.ow_step = s.ow_step + 3'd1;
					end else if (s.ow_step == 3'd2 || s.ow_step == 3'd3) begin
						// repeated runs drain charge left on an open input
						next_s.code    = bsm_pkg::CMD_OW;
						next_s.ow_step = 3'd3;
						next_s.ow_rep  = (s.ow_step == 3'd2) ? 8'h01 : s.ow_rep + 8'h01;
					end else begin
						next_s.st      = H_IDLE;
						next_s.done    = (s.ow_step == 3'd4);
						next_s.ow_step = 3'd0;
					end
				end
			end
			default: next_s.st = H_IDLE;
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s           <= '0;
			s.st        <= H_IDLE;
			s.code      <= bsm_pkg::CMD_CFG;
			s.pend_code <= bsm_pkg::CMD_CFG;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign link.cmd_valid = (s.st == H_SEND);
	assign link.cmd_code  = s.code;
	assign link.cmd_data  = s.data;
	assign user_cmd_ready = (s.st == H_IDLE);
	assign user_rsp_valid = s.rsp_valid;
	assign user_rsp_index = s.rsp_index;
	assign user_rsp_data  = s.rsp_data;
	assign open_mask      = s.mask;
	assign ow_done        = s.done;
endmodule // bsm_host
`default_nettype wire

// ===== testbench/cell_measure_discharge_ctrl_monitor.sv
// link checker for the host and measurement controller pair
`default_nettype none
module cell_measure_discharge_ctrl_monitor #(
	parameter int CONV_CYC = 8
) (
	input wire logic                       clk,       // clock
	input wire logic                       rst_n,     // sync reset
	input wire logic                       cmd_valid, // offered
	input wire logic                       cmd_ready, // device idle
	input wire bsm_pkg::cmd_e              cmd_code,  // command
	input wire logic [bsm_pkg::DATA_W-1:0] cmd_data,  // argument
	input wire logic                       rsp_valid, // word pulse
	input wire logic [3:0]                 rsp_index, // word index
	input wire logic [bsm_pkg::CODE_W-1:0] rsp_data,  // word value
	input wire logic                       rsp_last   // final word
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// config shadow and busy counter
	logic       ten;
	logic [2:0] cdc;
	logic       take;
	int         want;
	int         cnt;
	assign take = cmd_valid && cmd_ready;
	// run length in cycles; zero for non-conversions
	function automatic int runlen(bsm_pkg::cmd_e c, logic [15:0] d);
		case (c)
			bsm_pkg::CMD_TEMP, bsm_pkg::CMD_ST1_TEMP, bsm_pkg::CMD_ST2_TEMP: return 3 * CONV_CYC;
			bsm_pkg::CMD_ONE_CELL: return (d[3:0] < 4'hC) ? CONV_CYC : 0;
			bsm_pkg::CMD_CFG, bsm_pkg::CMD_RD_CELL, bsm_pkg::CMD_RD_TEMP, bsm_pkg::CMD_OW_CHECK: return 0;
			default: return (ten ? 10 : 12) * CONV_CYC;
		endcase
	endfunction
	// overheating is unseen here; the bench sends only reads after it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ten  <= 1'b0;
			cdc  <= 3'h0;
			want <= 0;
			cnt  <= 0;
		end else if (take) begin
			want <= (cdc == 3'h0) ? 0 : runlen(cmd_code, cmd_data);
			cnt  <= 0;
			if (cmd_code == bsm_pkg::CMD_CFG) begin
				ten <= cmd_data[bsm_pkg::CFG_TEN_BIT];
				cdc <= cmd_data[bsm_pkg::CFG_CDC_LSB +: 3];
			end
		end else if (!cmd_ready) begin
			cnt <= cnt + 1;
		end
	end
	// ==========
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_conv_time: assert property ($rose(cmd_ready) && want != 0 |-> cnt == want)
		else $error("run length wrong");
	a_standby_refuse: assert property (take && cdc == 3'h0 && runlen(cmd_code, cmd_data) != 0 |=> cmd_ready)
		else $error("standby run taken");
	a_read_first: assert property (take && cmd_code == bsm_pkg::CMD_RD_CELL |=> !rsp_valid ##1 rsp_valid && rsp_index == 4'h0)
		else $error("first word late");
	a_ten_words: assert property (take && cmd_code == bsm_pkg::CMD_RD_CELL && ten |-> ##11 rsp_last && rsp_index == 4'h9)
		else $error("ten-cell read length");
	a_twelve_words: assert property (take && cmd_code == bsm_pkg::CMD_RD_CELL && !ten |-> ##13 rsp_last && rsp_index == 4'hB)
		else $error("twelve-cell read length");
	a_temp_words: assert property (take && cmd_code == bsm_pkg::CMD_RD_TEMP |-> ##5 rsp_valid && rsp_last && rsp_index == 4'h3)
		else $error("temperature read length");
	a_index_steps: assert property (rsp_valid && !rsp_last |=> rsp_valid && rsp_index == $past(rsp_index) + 4'h1)
		else $error("word index skipped");
	a_busy_reading: assert property (rsp_valid && !rsp_last |-> !cmd_ready)
		else $error("ready during read");
	c_open_wire: cover property (take && cmd_code == bsm_pkg::CMD_OW);
	c_ten_read: cover property (rsp_last && rsp_index == 4'h9);
	c_temp_run: cover property ($rose(cmd_ready) && want == 3 * CONV_CYC);
endmodule // cell_measure_discharge_ctrl_monitor
`default_nettype wire

// ===== testbench/test_cell_measure_discharge_ctrl.sv
// bench joining host and measurement controller over the link
`default_nettype none
module test_cell_measure_discharge_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// signals
	typedef struct {bsm_pkg::cmd_e c; logic [15:0] cfg; logic [11:0] e; int n;} row_s;
	logic          clk, rst_n, cmd_valid, cmd_ready, rsp_valid, die_hot, cur_on, compare_active, standby, ow_seen;
	bsm_pkg::cmd_e cmd_code;
	logic [15:0]   cmd_data;
	logic [11:0]   rsp_data, adc_code, dis;
	logic [10:0]   open_mask;
	logic [3:0]    mux_chan;
	int            bad_count, compares, cyc, ow_runs;
	logic [11:0]   q[$];
	bsm_pkg::cmd_e gate[4] = '{bsm_pkg::CMD_CELL, bsm_pkg::CMD_OW, bsm_pkg::CMD_CELL_DC, bsm_pkg::CMD_OW_DC};
	row_s          rows[6] = '{'{bsm_pkg::CMD_ST1_CELL, 16'h4000, 12'h555, 12}, '{bsm_pkg::CMD_ST2_CELL, 16'h2000, 12'hAAA, 12},
		'{bsm_pkg::CMD_ST1_TEMP, 16'h2000, 12'h555, 3}, '{bsm_pkg::CMD_ST2_TEMP, 16'h2000, 12'hAAA, 3},
		'{bsm_pkg::CMD_CELL, 16'h3000, 12'h000, 10}, '{bsm_pkg::CMD_CELL_DC, 16'h2000, 12'h000, 12}};
	bsm_link link ();
	bsm_host i_bsm_host (.clk, .rst_n, .link, .user_cmd_valid(cmd_valid), .user_cmd_code(cmd_code),
		.user_cmd_data(cmd_data), .user_cmd_ready(cmd_ready), .user_rsp_valid(rsp_valid), .user_rsp_index(),
		.user_rsp_data(rsp_data), .open_mask, .ow_done());
	cell_measure_discharge_ctrl #(.CONV_CYC(8), .CMP_CYC(4), .CMP_PER(20)) i_cell_measure_discharge_ctrl (.clk, .rst_n,
		.link, .adc_code, .die_hot, .discharge_switch_output(dis), .mux_chan, .meas_temp(), .test_current_on(cur_on),
		.test_signal_on(), .compare_active, .standby);
	cell_measure_discharge_ctrl_monitor #(.CONV_CYC(8)) i_monitor (.clk, .rst_n, .cmd_valid(link.cmd_valid),
		.cmd_ready(link.cmd_ready), .cmd_code(link.cmd_code), .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid),
		.rsp_index(link.rsp_index), .rsp_data(link.rsp_data), .rsp_last(link.rsp_last));
	// ==========
	// clock, converter stand-in, watchers
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// cell k reads 0x400+k; current lifts cell 5 by the threshold, cell 8 by one less
	always @(posedge clk) begin
		adc_code <= 12'h400 + {8'h00, mux_chan} + (cur_on ? (mux_chan == 4'h5 ? 12'h0C8 : mux_chan == 4'h8 ? 12'h0C7 : 12'h000) : 12'h000);
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	// sampled at negedge, clear of the registered updates
	always @(negedge clk) begin
		if (rsp_valid === 1'b1)
			q.push_back(rsp_data);
		if (cur_on === 1'b1 && ow_seen !== 1'b1)
			ow_runs++;
		ow_seen = cur_on;
	end
	// ==========
	// tasks
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic idle();
		do @(negedge clk); while (cmd_ready !== 1'b1);
	endtask
	task automatic send(input bsm_pkg::cmd_e c, input logic [15:0] d);
		idle();
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code  <= c;
		cmd_data  <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		repeat (3) @(negedge clk);
		idle();
		repeat (3) @(negedge clk);
	endtask
	task automatic rd(input bsm_pkg::cmd_e c);
		q.delete();
		send(c, 16'h0000);
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========
	// main sequence
	initial begin
		{cmd_valid, rst_n, die_hot, ow_seen} = 4'h0;
		cmd_code = bsm_pkg::CMD_CFG;
		{cmd_data, adc_code} = 28'h0000000;
		{bad_count, compares, cyc, ow_runs} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("dis_rst", 16'h0000, {4'h0, dis});
		chk("standby", 16'h0001, {15'h0000, standby});
		rd(bsm_pkg::CMD_RD_CELL);
		chk("words_rst", 16'h000C, 16'(q.size()));
		send(bsm_pkg::CMD_CELL, 16'h0000);
		$display("reset test done");
		foreach (rows[i]) begin
			send(bsm_pkg::CMD_CFG, rows[i].cfg);
			send(rows[i].c, 16'h0000);
			rd(rows[i].n == 3 ? bsm_pkg::CMD_RD_TEMP : bsm_pkg::CMD_RD_CELL);
			chk("words", 16'(rows[i].n == 3 ? 4 : rows[i].n), 16'(q.size()));
			for (int k = 0; k < rows[i].n; k++)
				chk("code", {4'h0, rows[i].e != 12'h000 ? rows[i].e : 12'h400 + 12'(k)}, {4'h0, q[k]});
			$display("row %0d done", i);
		end
		foreach (gate[i]) begin
			send(bsm_pkg::CMD_CFG, 16'h2FFF);
			fork
				send(gate[i], 16'h0000);
				begin
					do @(negedge clk); while (mux_chan !== 4'h5);
					repeat (3) @(negedge clk);
					chk("gating", i < 2 ? 16'h0F8F : 16'h0FFF, {4'h0, dis});
				end
			join
		end
		// idle comparisons blank all switches, then the written pattern returns
		do @(negedge clk); while (compare_active !== 1'b1);
		repeat (2) @(negedge clk);
		chk("cmp_off", 16'h0000, {4'h0, dis});
		do @(negedge clk); while (compare_active !== 1'b0);
		repeat (2) @(negedge clk);
		chk("cmp_idle", 16'h0FFF, {4'h0, dis});
		$display("discharge tests done");
		// single cell over a self-test pattern leaves the other words alone
		send(bsm_pkg::CMD_ST1_CELL, 16'h0000);
		send(bsm_pkg::CMD_ONE_CELL, 16'h0004);
		send(bsm_pkg::CMD_ONE_CELL, 16'h000C);
		rd(bsm_pkg::CMD_RD_CELL);
		chk("one_cell", 16'h0404, {4'h0, q[4]});
		chk("untouched", 16'h0555, {4'h0, q[3]});
		ow_runs = 0;
		send(bsm_pkg::CMD_OW_CHECK, 16'h0000);
		chk("open_mask", 16'h0010, {5'h00, open_mask});
		chk("ow_runs", 16'h0003, 16'(ow_runs));
		$display("open wire test done");
		@(posedge clk);
		die_hot <= 1'b1;
		repeat (6) @(negedge clk);
		chk("hot_dis", 16'h0000, {4'h0, dis});
		chk("hot_stby", 16'h0001, {15'h0000, standby});
		@(posedge clk);
		die_hot <= 1'b0;
		rd(bsm_pkg::CMD_RD_TEMP);
		chk("flag_set", 16'h0001, {4'h0, q[3]});
		rd(bsm_pkg::CMD_RD_TEMP);
		chk("flag_clr", 16'h0000, {4'h0, q[3]});
		$display("thermal test done");
		conclude();
	end
endmodule // test_cell_measure_discharge_ctrl
`default_nettype wire
